/* bcbd_regs.vh */
/*
 * opcode encodings, field positions and widths for the bit, compare-skip and
 * branch decoder. assumes 9-bit instruction words and 4-bit data nibbles.
 */
`ifndef BCBD_REGS_VH
`define BCBD_REGS_VH

`define BCBD_IW          9
`define BCBD_SET_BASE    9'h05c
`define BCBD_CLR_BASE    9'h04c
`define BCBD_TST_BASE    9'h020
`define BCBD_BIT_MASK    9'h1fc
`define BCBD_CMP_MEM     9'h026
`define BCBD_CMP_IMM     9'h025
`define BCBD_IMM_BASE    9'h0b0
`define BCBD_IMM_MASK    9'h1f0
`define BCBD_FAR_BASE    9'h030
`define BCBD_FAR_MASK    9'h1f0
`define BCBD_IDX_NEAR    9'h001
`define BCBD_IDX_FAR     9'h010
`define BCBD_JMP_MSB     8
`define BCBD_JMP_LSB     7
`define BCBD_TGT_MSB     6
`define BCBD_IDX_MSB     6
`define BCBD_IDX_LSB     4
`define BCBD_PAGE_MSB    2
`define BCBD_BIT_MSB     1
`define BCBD_NIB_MSB     3
`define BCBD_PCL_RST     7'h00
`define BCBD_PCH_RST     3'h0
`define BCBD_JMP_TAG     2'b11
`define BCBD_NIB_RST     4'h0

`endif

/* bcbd_bit_unit.v */
/*
 * bit unit: sets, clears or reads one bit of a data nibble.
 * assumes the nibble is the word at the data pointer, valid this cycle.
 */
`timescale 1ns/100ps
`include "bcbd_regs.vh"

module bcbd_bit_unit (
  input  wire [3:0] nib_i,
  input  wire [1:0] sel_i,
  input  wire       set_i,
  output wire [3:0] set_nib_o,
  output wire [3:0] clr_nib_o,
  output wire       bit_o
);
  // one-hot mask for the chosen bit
  wire [3:0] mask;
  assign mask      = 4'h1 << sel_i;
  assign set_nib_o = nib_i | mask;
  assign clr_nib_o = nib_i & ~mask;
  assign bit_o     = |(nib_i & mask) & (set_i | ~set_i);
endmodule // bcbd_bit_unit

/* bcbd_core.v */
/*
 * bit / compare-skip / branch executor of a 4-bit core.
 * assumes one instruction word per enable pulse from program memory, and an
 * asynchronous data-memory read of the nibble at the data pointer.
 * assumes the fetch side increments the pc itself and gates its own decode
 * with skip_o; this block only loads jump targets.
 * a memory write lands one edge after its word, so a bit op followed at once
 * by a read of the same nibble sees the old value; leave one word between.
 */
// Overview of operation
// - set_mem_bit forces chosen memory bit high
// - clear_mem_bit forces chosen memory bit low
// - skip_if_bit_zero skips when bit is zero
// - skip_if_acc_eq_mem skips on equality, carry untouched
// - skip_if_acc_eq_imm two words, skips on match
// - in-page jump loads low pc part
// - far_jump loads page and low part
// - indexed jump uses a6..a4 and accumulator
// - indexed_far_jump takes page from second word
// - page numbers limited to 0..7
`timescale 1ns/100ps
`include "bcbd_regs.vh"

module bcbd_core #(
  parameter PAGE_W = 3
) (
  input  wire                 core_clk_i,
  input  wire                 sys_rst_i,
  input  wire                 instr_en_i,
  input  wire [8:0]           instr_i,
  input  wire [3:0]           acc_i,
  input  wire [3:0]           mem_rd_i,
  output reg  [3:0]           mem_wr_data_o,
  output reg                  mem_wr_o,
  output reg  [6:0]           pc_low_part_o,
  output reg  [PAGE_W-1:0]    pc_page_part_o,
  output reg                  skip_o
);

  // second-word states, one-hot
  localparam ST_IDLE = 5'b00001;
  localparam ST_IMM  = 5'b00010;
  localparam ST_FAR  = 5'b00100;
  localparam ST_IDXN = 5'b01000;
  localparam ST_IDXF = 5'b10000;

  reg [4:0]        state_r;
  reg [4:0]        state_nxt;
  reg [PAGE_W-1:0] page_r;
  reg [PAGE_W-1:0] page_nxt;
  reg              skip_r;
  reg              skip_nxt;
  reg              skip2_r;
  reg              skip2_nxt;
  reg [6:0]        pcl_nxt;
  reg [PAGE_W-1:0] pch_nxt;
  reg [3:0]        wd_nxt;
  reg              we_nxt;

  wire [3:0] set_nib;
  wire [3:0] clr_nib;
  wire       sel_bit;

  // true when the word is a two-word opcode leader
  function is_two_word;
    input [8:0] w;
    begin
      is_two_word = (w == `BCBD_CMP_IMM) || (w == `BCBD_IDX_NEAR) || (w == `BCBD_IDX_FAR) ||
                    ((w & `BCBD_FAR_MASK) == `BCBD_FAR_BASE);
    end
  endfunction

  // true when the word belongs to a bit-indexed group
  function bit_op;
    input [8:0] w;
    input [8:0] base;
    begin
      bit_op = (w & `BCBD_BIT_MASK) == base;
    end
  endfunction

  bcbd_bit_unit u_bit (
    .nib_i     (mem_rd_i),
    .sel_i     (instr_i[`BCBD_BIT_MSB:0]),
    .set_i     (1'b1),
    .set_nib_o (set_nib),
    .clr_nib_o (clr_nib),
    .bit_o     (sel_bit)
  );

  // opcode class decode of the word on the bus
  wire is_jump  = (instr_i[`BCBD_JMP_MSB:`BCBD_JMP_LSB] == `BCBD_JMP_TAG);
  wire dec_set  = bit_op(instr_i, `BCBD_SET_BASE);
  wire dec_clr  = bit_op(instr_i, `BCBD_CLR_BASE);
  wire dec_tst  = bit_op(instr_i, `BCBD_TST_BASE);
  wire dec_cmpm = (instr_i == `BCBD_CMP_MEM);
  wire dec_cmpi = (instr_i == `BCBD_CMP_IMM);
  wire dec_far  = ((instr_i & `BCBD_FAR_MASK) == `BCBD_FAR_BASE);
  wire dec_idxn = (instr_i == `BCBD_IDX_NEAR);
  wire dec_idxf = (instr_i == `BCBD_IDX_FAR);
  wire imm_ok   = ((instr_i & `BCBD_IMM_MASK) == `BCBD_IMM_BASE);

  // a live first word: not dropped and not the tail of a two-word op;
  // gating writes with it keeps a dropped word from touching memory
  wire exec_first = instr_en_i && (state_r == ST_IDLE) && !skip_r && !skip2_r;

  // memory write path; only a live first word may write
  always @* begin
    wd_nxt = mem_wr_data_o;
    we_nxt = 1'b0;
    if (exec_first && dec_set) begin
      wd_nxt = set_nib;
      we_nxt = 1'b1;
    end else if (exec_first && dec_clr) begin
      wd_nxt = clr_nib;
      we_nxt = 1'b1;
    end
  end

  // decode and execute one word per enable
  always @* begin
    state_nxt = state_r;
    page_nxt  = page_r;
    skip_nxt  = skip_r;
    skip2_nxt = skip2_r;
    pcl_nxt   = pc_low_part_o;
    pch_nxt   = pc_page_part_o;
    if (instr_en_i) begin
      case (state_r)
        ST_IDLE: begin
          if (skip_r) begin
            // fetched but dropped; a two-word victim drops its tail too
            skip_nxt  = 1'b0;
            skip2_nxt = is_two_word(instr_i);
          end else if (skip2_r) begin
            skip2_nxt = 1'b0;
          end else if (dec_tst) begin
            skip_nxt = ~sel_bit;
          end else if (dec_cmpm) begin
            skip_nxt = (acc_i == mem_rd_i);
          end else if (dec_cmpi) begin
            state_nxt = ST_IMM;
          end else if (dec_far) begin
            page_nxt  = instr_i[PAGE_W-1:0];
            state_nxt = ST_FAR;
          end else if (dec_idxn) begin
            state_nxt = ST_IDXN;
          end else if (dec_idxf) begin
            state_nxt = ST_IDXF;
          end else if (is_jump) begin
            pcl_nxt = instr_i[`BCBD_TGT_MSB:0];
          end
        end
        ST_IMM: begin
          // malformed second word is ignored rather than compared
          if (imm_ok)
            skip_nxt = (acc_i == instr_i[`BCBD_NIB_MSB:0]);
          state_nxt = ST_IDLE;
        end
        ST_FAR: begin
          pch_nxt   = page_r;
          pcl_nxt   = instr_i[`BCBD_TGT_MSB:0];
          state_nxt = ST_IDLE;
        end
        ST_IDXN: begin
          pcl_nxt   = {instr_i[`BCBD_IDX_MSB:`BCBD_IDX_LSB], acc_i};
          state_nxt = ST_IDLE;
        end
        ST_IDXF: begin
          pch_nxt   = instr_i[`BCBD_PAGE_MSB:0];
          pcl_nxt   = {instr_i[`BCBD_IDX_MSB:`BCBD_IDX_LSB], acc_i};
          state_nxt = ST_IDLE;
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // sequencer state: word position, latched page and drop flags
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      page_r  <= `BCBD_PCH_RST;
      skip_r  <= 1'b0;
      skip2_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      page_r  <= page_nxt;
      skip_r  <= skip_nxt;
      skip2_r <= skip2_nxt;
    end
  end

  // program counter parts; only jumps load them
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pc_low_part_o  <= `BCBD_PCL_RST;
      pc_page_part_o <= `BCBD_PCH_RST;
    end else begin
      pc_low_part_o  <= pcl_nxt;
      pc_page_part_o <= pch_nxt;
    end
  end

  // memory write port; the strobe is a one-cycle pulse, so the nibble
  // lands one edge after the word that asked for it
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_wr_data_o <= `BCBD_NIB_RST;
      mem_wr_o      <= 1'b0;
    end else begin
      mem_wr_data_o <= wd_nxt;
      mem_wr_o      <= we_nxt;
    end
  end

  // skip output mirrors both drop flags so the fetch side can gate its decode
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      skip_o <= 1'b0;
    else
      skip_o <= skip_nxt | skip2_nxt;
  end
endmodule // bcbd_core

/* bcbd_chk_sva.sv */
/* port checker for bcbd_core.
   assumes one word per enabled edge and results one edge later. */
`timescale 1ns/100ps
module bcbd_chk #(parameter PAGE_W = 3) (
  input wire              core_clk_i,
  input wire              sys_rst_i,
  input wire              instr_en_i,
  input wire [8:0]        instr_i,
  input wire [3:0]        acc_i,
  input wire [3:0]        mem_rd_i,
  input wire [3:0]        mem_wr_data_o,
  input wire              mem_wr_o,
  input wire [6:0]        pc_low_part_o,
  input wire [PAGE_W-1:0] pc_page_part_o,
  input wire              skip_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire two_w = instr_i == 9'h025 || instr_i[8:4] == 5'h03 || instr_i == 9'h001 || instr_i == 9'h010;
  reg       pend_r;
  reg       live_r;
  reg [8:0] w1_r;
  // track word position; a skipped first word still eats its second
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_r <= 1'b0;
      live_r <= 1'b0;
      w1_r   <= 9'h000;
    end else if (instr_en_i) begin
      pend_r <= !pend_r && two_w;
      live_r <= !skip_o;
      w1_r   <= instr_i;
    end
  end
  wire go1 = instr_en_i && !pend_r && !skip_o;
  wire go2 = instr_en_i && pend_r && live_r;
  sequence s_far;
    go1 && instr_i[8:4] == 5'h03 ##1 instr_en_i && instr_i[8:7] == 2'b11;
  endsequence
  a_set_bit_write: assert property (go1 && instr_i[8:2] == 7'h17 |=> mem_wr_o &&
    mem_wr_data_o == ($past(mem_rd_i) | (4'h1 << $past(instr_i[1:0])))) else $error("set bit wrong");
  a_clr_bit_write: assert property (go1 && instr_i[8:2] == 7'h13 |=> mem_wr_o &&
    mem_wr_data_o == ($past(mem_rd_i) & ~(4'h1 << $past(instr_i[1:0])))) else $error("clear bit wrong");
  a_bit_test_skip: assert property (go1 && instr_i[8:2] == 7'h08 |=>
    skip_o == !$past(mem_rd_i[instr_i[1:0]])) else $error("bit test skip wrong");
  a_mem_cmp_skip: assert property (go1 && instr_i == 9'h026 |=>
    skip_o == $past(acc_i == mem_rd_i) && !mem_wr_o) else $error("memory compare wrong");
  a_imm_cmp_skip: assert property (go2 && w1_r == 9'h025 && instr_i[8:4] == 5'h0b |=>
    skip_o == $past(acc_i == instr_i[3:0])) else $error("immediate compare wrong");
  a_near_jump_load: assert property (go1 && instr_i[8:7] == 2'b11 |=>
    pc_low_part_o == $past(instr_i[6:0]) && $stable(pc_page_part_o)) else $error("near jump wrong");
  a_far_jump_load: assert property (s_far |=> pc_page_part_o == $past(instr_i[2:0], 2) &&
    pc_low_part_o == $past(instr_i[6:0])) else $error("far jump wrong");
  a_idx_near_jump: assert property (go2 && w1_r == 9'h001 |=> $stable(pc_page_part_o) &&
    pc_low_part_o == {$past(instr_i[6:4]), $past(acc_i)}) else $error("indexed jump wrong");
  a_idx_far_jump: assert property (go2 && w1_r == 9'h010 |=> pc_page_part_o == $past(instr_i[2:0]) &&
    pc_low_part_o == {$past(instr_i[6:4]), $past(acc_i)}) else $error("indexed far jump wrong");
  a_skip_no_effect: assert property (instr_en_i && skip_o |=> !mem_wr_o &&
    $stable(pc_low_part_o) && $stable(pc_page_part_o)) else $error("skipped word took effect");
endmodule // bcbd_chk
bind bcbd_core bcbd_chk #(.PAGE_W(PAGE_W)) u_bcbd_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .instr_en_i(instr_en_i), .instr_i(instr_i), .acc_i(acc_i), .mem_rd_i(mem_rd_i), .mem_wr_data_o(mem_wr_data_o),
  .mem_wr_o(mem_wr_o), .pc_low_part_o(pc_low_part_o), .pc_page_part_o(pc_page_part_o), .skip_o(skip_o));

/* bcbd_mem_model.sv */
/* data nibble at the data pointer.
   assumes the bench preloads it; core writes win over a preload. */
`timescale 1ns/100ps
module bcbd_mem_model (
  input  wire       core_clk_i,
  input  wire       wr_i,
  input  wire [3:0] wr_data_i,
  input  wire       load_i,
  input  wire [3:0] load_data_i,
  output reg  [3:0] rd_data_o
);
  // read is combinational from the held nibble
  always @(posedge core_clk_i) begin
    if (wr_i)
      rd_data_o <= wr_data_i;
    else if (load_i)
      rd_data_o <= load_data_i;
  end
endmodule // bcbd_mem_model

/* bcbd_core_bench.sv */
/* random bench for bcbd_core with a data nibble model.
   assumes words taken one edge after issue, results one edge later. */
`timescale 1ns/100ps
module bcbd_core_bench;
  reg        clk = 0;
  reg        rst = 1;
  reg        en = 0;
  reg  [8:0] ins = 9'h000;
  reg  [3:0] acc = 4'h0;
  reg        ld = 0;
  reg  [3:0] ld_d = 4'h0;
  wire [3:0] rd, wd;
  wire       wr, skip;
  wire [6:0] pc_low_part;
  wire [2:0] pg;
  integer    seed = 32'ha1d8;
  integer    n_mismatch = 0, n_compared = 0, i;
  reg  [3:0] m, n;
  reg  [1:0] j;
  reg  [6:0] t, e_pc;
  reg  [2:0] p, e_pg;
  always #10 clk = ~clk;
  bcbd_core u_bcbd_core (.core_clk_i(clk), .sys_rst_i(rst), .instr_en_i(en), .instr_i(ins), .acc_i(acc),
    .mem_rd_i(rd), .mem_wr_data_o(wd), .mem_wr_o(wr), .pc_low_part_o(pc_low_part), .pc_page_part_o(pg), .skip_o(skip));
  bcbd_mem_model u_bcbd_mem_model (.core_clk_i(clk), .wr_i(wr), .wr_data_i(wd), .load_i(ld),
    .load_data_i(ld_d), .rd_data_o(rd));
  function [3:0] put(input [3:0] v, input [1:0] b, input s);
    put = s ? v | (4'h1 << b) : v & ~(4'h1 << b);
  endfunction
  task chk(input [8:0] seen, input [8:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // en stays high across back-to-back words; idle drops it
  task op(input [8:0] w);
    begin
      en = 1;
      ins = w;
      @(posedge clk) #1;
    end
  endtask
  task idle;
    begin
      en = 0;
      @(posedge clk) #1;
    end
  endtask
  task final_report;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #1000000 n_mismatch = n_mismatch + 1;
    final_report;
  end
  // each pass: bit ops, compares with far and near jump victims, then both indexed jumps
  initial begin
    e_pc = 0;
    e_pg = 0;
    repeat (6) @(posedge clk);
    #1 rst = 0;
    for (i = 0; i < 48; i = i + 1) begin
      // a second reset in mid-run; pc, page, skip and write strobe must come back to zero
      if (i == 24) begin
        rst = 1;
        idle;
        rst = 0;
        e_pc = 7'h00;
        e_pg = 3'h0;
      end
      if (i == 0 || i == 24) begin
        chk(pc_low_part, 7'h00);
        chk(pg, 3'h0);
        chk(skip, 1'b0);
        chk(wr, 1'b0);
      end
      j = i;
      m = $random(seed);
      t = $random(seed);
      p = $random(seed);
      ld = 1;
      ld_d = m;
      idle;
      ld = 0;
      op(9'h020 + j); chk(skip, !m[j]);
      op(9'h05c + (j ^ 2'h1)); idle; if (m[j]) m = put(m, j ^ 2'h1, 1); chk(rd, m);
      op(9'h05c + j); idle; m = put(m, j, 1); chk(rd, m);
      op(9'h04c + j); idle; m = put(m, j, 0); chk(rd, m);
      acc = i[0] ? m : $random(seed);
      n = (i % 3 == 0) ? acc : $random(seed);
      op(9'h026); chk(skip, acc == m);
      op(9'h030 | p); op({2'b11, t}); idle; if (acc != m) {e_pg, e_pc} = {p, t};
      chk(pg, e_pg); chk(pc_low_part, e_pc);
      op(9'h025); op(9'h0b0 | n); chk(skip, acc == n);
      op({2'b11, t ^ 7'h55}); idle; if (acc != n) e_pc = t ^ 7'h55; chk(pc_low_part, e_pc);
      op(9'h025); op(9'h0c0 | n); chk(skip, 1'b0);
      op(9'h001); op({2'b11, t}); idle; e_pc = {t[6:4], acc}; chk(pc_low_part, e_pc); chk(pg, e_pg);
      op(9'h010); op({2'b11, ~t[6:4], 1'b0, p}); idle; e_pg = p; e_pc = {~t[6:4], acc};
      chk(pg, e_pg); chk(pc_low_part, e_pc);
    end
    final_report;
  end
endmodule // bcbd_core_bench
